// ===== rtl/rsl_regs.vh
// register offsets, field positions and reset values of the reset state loader
`ifndef RSL_REGS_VH
`define RSL_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define RSL_OFS_INDIRECT_DATA    8'h00
`define RSL_OFS_TIMER_COUNT      8'h01
`define RSL_OFS_PC_LOW           8'h02
`define RSL_OFS_CORE_STATUS      8'h03
`define RSL_OFS_INDIRECT_POINTER 8'h04
`define RSL_OFS_OSC_TRIM         8'h05
`define RSL_OFS_PORT_PINS        8'h06
`define RSL_OFS_OPTION_CONFIG    8'h08
`define RSL_OFS_DIRECTION        8'h09
`define RSL_OFS_ACCUM            8'h0a
`define RSL_OFS_RESET_REQ        8'h0b
`define RSL_OFS_CAUSE            8'h0c

// ****************************************************************
// status fields
// ****************************************************************
`define RSL_ST_WAKE_BIT          7
`define RSL_ST_TIMEOUT_BIT       4
`define RSL_ST_POWERDOWN_BIT     3
`define RSL_ST_LOW_MSB           2

// ****************************************************************
// reset request bits and cause codes
// ****************************************************************
`define RSL_REQ_POR_BIT          0
`define RSL_REQ_CLEAR_BIT        1
`define RSL_REQ_WDOG_BIT         2
`define RSL_REQ_WAKE_BIT         3
`define RSL_REQ_SLEEP_BIT        4

`define RSL_CAUSE_NONE           3'h0
`define RSL_CAUSE_POR            3'h1
`define RSL_CAUSE_CLR_RUN        3'h2
`define RSL_CAUSE_CLR_SLEEP      3'h3
`define RSL_CAUSE_WDT_SLEEP      3'h4
`define RSL_CAUSE_WDT_RUN        3'h5
`define RSL_CAUSE_WAKE           3'h6

// ****************************************************************
// reset values
// ****************************************************************
`define RSL_RST_PC_LOW           8'hff
`define RSL_RST_DIRECTION        8'hff
`define RSL_RST_OPTION           8'hff
`define RSL_RST_STATUS_POR       8'h18
`define RSL_RST_ZERO             8'h00

`endif

// ===== rtl/rsl_cause_prio.v
// reset cause priority encoder
module rsl_cause_prio (
  input  wire       power_on,
  input  wire       clear_pin,
  input  wire       watchdog,
  input  wire       wake_pin,
  input  wire       asleep,
  output reg  [2:0] cause
);
`include "rsl_regs.vh"

  always @* begin
    if (power_on) begin
      cause = `RSL_CAUSE_POR; // R13
    end else if (clear_pin) begin
      cause = asleep ? `RSL_CAUSE_CLR_SLEEP : `RSL_CAUSE_CLR_RUN;
    end else if (watchdog) begin
      cause = asleep ? `RSL_CAUSE_WDT_SLEEP : `RSL_CAUSE_WDT_RUN;
    end else if (wake_pin && asleep) begin
      cause = `RSL_CAUSE_WAKE;
    end else begin
      cause = `RSL_CAUSE_NONE;
    end
  end

endmodule

// ===== rtl/rsl_status_next.v
// status value loaded for each reset cause
module rsl_status_next (
  input  wire [2:0] cause,
  input  wire [7:0] status_now,
  output reg  [7:0] status_new
);
`include "rsl_regs.vh"

  // undefined bits of a power-on load are given zero
  always @* begin
    case (cause)
      `RSL_CAUSE_POR:       status_new = `RSL_RST_STATUS_POR;                // R01
      `RSL_CAUSE_CLR_RUN:   status_new = {3'b000, status_now[4:0]};          // R02
      `RSL_CAUSE_CLR_SLEEP: status_new = {4'b0001, 1'b0, status_now[2:0]};   // R03
      `RSL_CAUSE_WDT_SLEEP: status_new = {4'b0000, 1'b0, status_now[2:0]};   // R04
      `RSL_CAUSE_WDT_RUN:   status_new = {4'b0000, status_now[3:0]};         // R05
      `RSL_CAUSE_WAKE:      status_new = {4'b1001, 1'b0, status_now[2:0]};   // R06 R07
      default:              status_new = status_now;
    endcase
  end

endmodule

// ===== rtl/rsl_loader.v
// reset state loader: special registers, reset cause recording and register port
//
// Chosen here: the plain strobed port.

// Overview of operation
// R01: power-on loads status 0001 1xxx
// R02: clear pin running clears status upper three
// R03: clear pin asleep loads 0001 0uuu
// R04: watchdog asleep loads 0000 0uuu
// R05: watchdog running loads 0000 uuuu
// R06: pin-change wake-up loads 1001 0uuu
// R07: status bit seven only on wake-up
// R08: accumulator upper six take trim literal
// R09: unimplemented bits read zero
// R10: data registers kept except on power-on
// R11: every reset loads counter low all ones
// R12: direction registers forced all ones
// R13: power-on wins over other causes
module rsl_loader #(
  parameter [5:0] TRIM_LITERAL = 6'h20
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire       power_on_req,
  input  wire       clear_pin_req,
  input  wire       watchdog_req,
  input  wire       wake_pin_req,
  input  wire       sleep_in,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg  [7:0] pc_low_out,
  output reg  [7:0] direction_out,
  output reg  [7:0] accum_out,
  output reg        reset_pulse
);
`include "rsl_regs.vh"

  // ****************************************************************
  // state
  // ****************************************************************
  reg  [7:0] indirect_data_q;
  reg  [7:0] timer_count_q;
  reg  [7:0] status_q;
  reg  [7:0] indirect_pointer_q;
  reg  [7:0] osc_trim_q;
  reg  [5:0] port_pins_q;
  reg  [7:0] option_q;
  // the sleep request bit is kept in sleep_q, not here
  reg  [3:0] sw_req_q;
  reg  [2:0] last_cause_q;
  reg        sleep_q;
  wire [2:0] cause;
  wire [7:0] status_new;
  wire       any_reset;

  // software may also raise a reset cause through its own request register
  rsl_cause_prio u_prio (
    .power_on  (power_on_req  | rst | sw_req_q[`RSL_REQ_POR_BIT]),
    .clear_pin (clear_pin_req | sw_req_q[`RSL_REQ_CLEAR_BIT]),
    .watchdog  (watchdog_req  | sw_req_q[`RSL_REQ_WDOG_BIT]),
    .wake_pin  (wake_pin_req  | sw_req_q[`RSL_REQ_WAKE_BIT]),
    .asleep    (sleep_in | sleep_q),
    .cause     (cause)
  );

  rsl_status_next u_status (
    .cause      (cause),
    .status_now (status_q),
    .status_new (status_new)
  );

  assign any_reset = (cause != `RSL_CAUSE_NONE);

  // ****************************************************************
  // reset loading and software writes
  // ****************************************************************
  always @(posedge mclk) begin
    sw_req_q    <= 4'h0;
    reset_pulse <= any_reset;
    if (any_reset) begin
      status_q      <= status_new;                        // R01 R02 R03 R04 R05 R06 R07
      pc_low_out    <= `RSL_RST_PC_LOW;                   // R11
      direction_out <= `RSL_RST_DIRECTION;                // R12
      option_q      <= `RSL_RST_OPTION;
      accum_out     <= {TRIM_LITERAL, 2'b00};             // R08
      last_cause_q  <= cause;
      sleep_q       <= 1'b0;
      if (cause == `RSL_CAUSE_POR) begin
        // undefined contents after power-on are given zero, the oscillator trim the trim literal
        indirect_data_q    <= `RSL_RST_ZERO;              // R10
        timer_count_q      <= `RSL_RST_ZERO;
        indirect_pointer_q <= `RSL_RST_ZERO;
        osc_trim_q         <= {TRIM_LITERAL, 2'b00};
        port_pins_q        <= 6'h00;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `RSL_OFS_INDIRECT_DATA:    indirect_data_q    <= reg_wdata;
        `RSL_OFS_TIMER_COUNT:      timer_count_q      <= reg_wdata;
        `RSL_OFS_PC_LOW:           pc_low_out         <= reg_wdata;
        // cause bits 7, 4, 3 are hardware owned
        `RSL_OFS_CORE_STATUS:      status_q <= {status_q[7], reg_wdata[6:5],
                                                status_q[4:3], reg_wdata[2:0]};
        `RSL_OFS_INDIRECT_POINTER: indirect_pointer_q <= reg_wdata;
        `RSL_OFS_OSC_TRIM:         osc_trim_q         <= reg_wdata;
        `RSL_OFS_PORT_PINS:        port_pins_q        <= reg_wdata[5:0];
        `RSL_OFS_OPTION_CONFIG:    option_q           <= reg_wdata;
        `RSL_OFS_DIRECTION:        direction_out      <= reg_wdata;
        `RSL_OFS_ACCUM:            accum_out          <= reg_wdata;
        `RSL_OFS_RESET_REQ:        begin
          sw_req_q <= reg_wdata[3:0];
          sleep_q  <= reg_wdata[`RSL_REQ_SLEEP_BIT];
        end
        default:                   sleep_q <= sleep_q;
      endcase
    end
  end

  // ****************************************************************
  // read port, data one cycle after the strobe
  // ****************************************************************
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RSL_OFS_INDIRECT_DATA:    reg_rdata <= indirect_data_q;
        `RSL_OFS_TIMER_COUNT:      reg_rdata <= timer_count_q;
        `RSL_OFS_PC_LOW:           reg_rdata <= pc_low_out;
        `RSL_OFS_CORE_STATUS:      reg_rdata <= status_q;
        `RSL_OFS_INDIRECT_POINTER: reg_rdata <= indirect_pointer_q;
        `RSL_OFS_OSC_TRIM:         reg_rdata <= osc_trim_q;
        `RSL_OFS_PORT_PINS:        reg_rdata <= {2'b00, port_pins_q};    // R09
        `RSL_OFS_ACCUM:            reg_rdata <= accum_out;
        `RSL_OFS_CAUSE:            reg_rdata <= {5'h00, last_cause_q};   // R09
        // option and direction are write-only; unmapped reads zero
        default:                   reg_rdata <= 8'h00;                   // R09
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ===== testbench/rsl_loader_monitor.sv
// port assertions for the reset state loader
module rsl_loader_monitor #(
  parameter logic [5:0] TRIM_LITERAL = 6'h20
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       power_on_req,
  input wire logic       clear_pin_req,
  input wire logic       watchdog_req,
  input wire logic       wake_pin_req,
  input wire logic       sleep_in,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pc_low_out,
  input wire logic [7:0] direction_out,
  input wire logic [7:0] accum_out,
  input wire logic       reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire any_c = power_on_req | clear_pin_req | watchdog_req | (wake_pin_req & sleep_in);
  sequence s_rd_st; reg_rd && reg_addr == 8'h03; endsequence
  property p_pc; any_c |=> pc_low_out == 8'hff; endproperty
  a_pc: assert property (p_pc) else $error("pc low not loaded");
  property p_dir; any_c |=> direction_out == 8'hff; endproperty
  a_dir: assert property (p_dir) else $error("direction not forced");
  property p_acc; power_on_req |=> accum_out[7:2] == TRIM_LITERAL; endproperty
  a_acc: assert property (p_acc) else $error("trim not loaded");
  property p_por; power_on_req ##2 s_rd_st |=> reg_rdata == 8'h18; endproperty
  a_por: assert property (p_por) else $error("power-on status wrong");
  property p_wake; (wake_pin_req && sleep_in && !power_on_req && !clear_pin_req
    && !watchdog_req) ##2 s_rd_st |=> reg_rdata[7:3] == 5'h12; endproperty
  a_wake: assert property (p_wake) else $error("wake status wrong");
  property p_wdt; (watchdog_req && !sleep_in && !power_on_req && !clear_pin_req)
    ##2 s_rd_st |=> reg_rdata[7:4] == 4'h0; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog status wrong");
  property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_void; reg_rd && (reg_addr inside {8'h08, 8'h09} || reg_addr > 8'h0c)
    |=> reg_rdata == 8'h00; endproperty
  a_void: assert property (p_void) else $error("unmapped read not zero");
  property p_pulse; any_c |=> reset_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse missing");
endmodule
bind rsl_loader rsl_loader_monitor #(.TRIM_LITERAL(TRIM_LITERAL)) mon_u (.mclk, .rst,
  .power_on_req, .clear_pin_req, .watchdog_req, .wake_pin_req, .sleep_in, .reg_addr,
  .reg_rd, .reg_rdata, .pc_low_out, .direction_out, .accum_out, .reset_pulse);

// ===== testbench/rsl_loader_tb.sv
// self-checking bench of the reset state loader
module rsl_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals and design
  // ****
  localparam logic [5:0] TRIM = 6'h2d;
  logic       mclk = 0, rst = 1, por = 0, clr = 0, wdt = 0, wak = 0, slp = 0;
  logic       wr = 0, rd = 0, pulse, rs;
  logic [7:0] addr = 0, wd = 0, rdata, pc, dir, acc, st, tm, v;
  logic [4:0] c;
  int         fail_count = 0, compares = 0;
  always #20 mclk = ~mclk;
  rsl_loader #(.TRIM_LITERAL(TRIM)) dut_u (.mclk, .rst, .power_on_req(por),
    .clear_pin_req(clr), .watchdog_req(wdt), .wake_pin_req(wak), .sleep_in(slp),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .pc_low_out(pc), .direction_out(dir), .accum_out(acc), .reset_pulse(pulse));
  // ****
  // tasks and expectations
  // ****
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    bus(0, a, 8'h00);
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  // cause bits: 0 power-on, 1 clear pin, 2 watchdog, 3 pin change, 4 asleep
  task automatic hit(logic [4:0] k);
    @(posedge mclk);
    {slp, wak, wdt, clr, por} <= k;
    @(posedge mclk);
    {slp, wak, wdt, clr, por} <= 5'h00;
  endtask
  function automatic logic [7:0] nst(logic [4:0] k, logic [7:0] s);
    if (k[0]) return 8'h18;
    if (k[1]) return k[4] ? {5'h02, s[2:0]} : {3'h0, s[4:0]};
    if (k[2]) return k[4] ? {5'h00, s[2:0]} : {4'h0, s[3:0]};
    if (k[3] && k[4]) return {5'h12, s[2:0]};
    return s;
  endfunction
  function automatic logic [7:0] ncs(logic [4:0] k);
    if (k[0]) return 8'h01;
    if (k[1]) return k[4] ? 8'h03 : 8'h02;
    if (k[2]) return k[4] ? 8'h04 : 8'h05;
    return k[4] ? 8'h06 : 8'h00;
  endfunction
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    void'($urandom(32'h0000_280d));
    repeat (4) @(posedge mclk);
    rst <= 0;
    rdc(8'h03, 8'h18);
    rdc(8'h0c, 8'h01);
    chk("trim", {2'b00, TRIM}, {2'b00, acc[7:2]});
    chk("dir", 8'hff, dir);
    rdc(8'h08, 8'h00);
    rdc(8'h0f, 8'h00);
    st = 8'h18;
    for (int i = 0; i < 40; i++) begin
      // first the fixed corners, then every cause together, then random
      c = i < 8 ? {i[0], 4'h1 << i[2:1]} : i == 8 ? 5'h1f
        : {1'($urandom % 2), 4'h1 << ($urandom % 4)};
      v = 8'($urandom);
      bus(1, 8'h03, v);
      st = (st & 8'h98) | (v & 8'h67);
      tm = 8'($urandom);
      bus(1, 8'h01, tm);
      bus(1, 8'h02, 8'h3c);
      hit(c);
      rs = c[0] | c[1] | c[2] | (c[3] & c[4]);
      st = nst(c, st);
      if (c[0]) tm = 8'h00;
      rdc(8'h03, st);
      rdc(8'h01, tm);
      chk("pc", rs ? 8'hff : 8'h3c, pc);
      if (rs) rdc(8'h0c, ncs(c));
    end
    // software reset request: watchdog with the sleep flag set
    bus(1, 8'h09, 8'h5a);
    bus(1, 8'h0a, 8'h00);
    chk("dir wr", 8'h5a, dir);
    bus(1, 8'h0b, 8'h14);
    st = nst(5'h14, st);
    rdc(8'h03, st);
    rdc(8'h0c, 8'h04);
    chk("dir", 8'hff, dir);
    chk("acc", {TRIM, 2'b00}, acc);
    chk("pc", 8'hff, pc);
    // mid-run power-on through the reset input
    @(posedge mclk);
    rst <= 1;
    @(posedge mclk);
    rst <= 0;
    rdc(8'h03, 8'h18);
    rdc(8'h0c, 8'h01);
    rdc(8'h01, 8'h00);
    conclude();
  end
  initial begin
    #200us;
    fail_count++;
    conclude();
  end
endmodule
